//--- src/aac_pkg.sv
package aac_pkg;

  // Register map
  localparam logic [7:0] AAC_ADDR_START  = 8'hD8;
  localparam logic [7:0] AAC_ADDR_BATRES = 8'hDF;
  localparam logic [7:0] AAC_ADDR_ENABLE = 8'hEC;
  localparam logic [7:0] AAC_ADDR_EXTRES = 8'hEF;
  localparam logic [7:0] AAC_ADDR_DELTA  = 8'hF3;
  localparam logic [7:0] AAC_ADDR_FLAGS  = 8'hF8;
  localparam logic [7:0] AAC_ADDR_INTV   = 8'hF9;
  localparam logic [7:0] AAC_ADDR_THRESH = 8'hFA;

  // Field positions
  localparam int AAC_START_BAT_BIT = 0;
  localparam int AAC_START_EXT_BIT = 2;
  localparam int AAC_FLAG_BAT_BIT  = 2;
  localparam int AAC_FLAG_EXT_BIT  = 3;
  localparam int AAC_INTV_BAT_LSB  = 0;
  localparam int AAC_INTV_EXT_LSB  = 2;
  localparam int AAC_INTV_W        = 2;
  localparam int AAC_DELTA_W       = 3;

  // Reset values
  localparam logic [7:0] AAC_RST_BYTE = 8'h00;

  // Timing: background interval unit is one tick
  localparam int unsigned AAC_CLK_HZ  = 10_000_000;
  localparam int unsigned AAC_TICK_MS = 250;
  localparam int unsigned AAC_TICK_CYCLES =
    (AAC_CLK_HZ / 1000) * AAC_TICK_MS;

  typedef enum logic [1:0] {
    AAC_MODE_NORMAL  = 2'b00,
    AAC_MODE_BATTERY = 2'b01,
    AAC_MODE_SLEEP   = 2'b10
  } aac_mode_t;

endpackage

//--- src/aac_delta_cmp.sv
`timescale 1ns/1ns
module aac_delta_cmp
  import aac_pkg::*;
(
  input  wire logic [7:0]             new_i,
  input  wire logic [7:0]             ref_i,
  input  wire logic [AAC_DELTA_W-1:0] delta_i,
  output logic                        exceed_o
);
  logic [7:0] diff;

  always_comb begin
    if (new_i > ref_i) begin
      diff = new_i - ref_i;
    end else begin
      diff = ref_i - new_i;
    end
    exceed_o = diff > {{(8-AAC_DELTA_W){1'b0}}, delta_i};
  end
endmodule // aac_delta_cmp

//--- src/aac_intv_timer.sv
`timescale 1ns/1ns
module aac_intv_timer
  import aac_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  tick_i,
  input  wire logic                  enable_i,
  input  wire logic [AAC_INTV_W-1:0] period_i,
  output logic                       fire_o
);
  logic [AAC_INTV_W-1:0] cnt_r;

  // Restart from zero whenever disabled
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      fire_o <= 1'b0;
    end else if (!enable_i || period_i == '0) begin
      cnt_r  <= '0;
      fire_o <= 1'b0;
    end else if (tick_i) begin
      if (cnt_r == period_i - 1'b1) begin
        cnt_r  <= '0;
        fire_o <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + 1'b1;
        fire_o <= 1'b0;
      end
    end else begin
      fire_o <= 1'b0;
    end
  end
endmodule // aac_intv_timer

//--- src/aac_adc_ctrl.sv
`timescale 1ns/1ns
// Overview of operation
// - Normal mode: battery conversions from background and from single starts.
// - Battery mode: battery conversion only on single start, no background.
// - Sleep mode: no battery conversions at all.
// - Battery event when result below threshold or single conversion done.
// - Battery result loads only together with setting the low-battery flag.
// - Enabled low-battery flag drives the power-management interrupt.
// - External voltage result held in an 8-bit register.
// - Single external start gives interrupt with result in place.
// - External background off after reset; runs only with nonzero interval.
// - Background result differing beyond delta sets the change flag.
// - Change flag reaches interrupt only while its enable bit is set.
// - Battery mode: external conversions only from single start.
// - Sleep mode: external background conversions continue, only source.
// - Normal mode: external conversions from background and single starts.
// - External result updates only on an external interrupt event.
// - External event on delta or single done; no dedicated flag.
// - Start bits self-clear once the converter takes the request.
module aac_adc_ctrl
  import aac_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = AAC_TICK_CYCLES
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire aac_pkg::aac_mode_t  power_mode_i,
  input  wire logic [7:0]          sfr_addr_i,
  input  wire logic [7:0]          sfr_wdata_i,
  input  wire logic                sfr_wr_i,
  input  wire logic                sfr_rd_i,
  output logic [7:0]               sfr_rdata_o,
  output logic                     bat_conv_req_o,
  input  wire logic                bat_conv_done_i,
  input  wire logic [7:0]          bat_conv_data_i,
  output logic                     ext_conv_req_o,
  input  wire logic                ext_conv_done_i,
  input  wire logic [7:0]          ext_conv_data_i,
  output logic                     psm_irq_o,
  output logic                     ext_adc_irq_o
);
  import aac_pkg::*;

  logic [31:0]            tick_cnt_r;
  logic                   tick_r;
  logic                   bat_start_r;
  logic                   ext_start_r;
  logic [7:0]             bat_result_r;
  logic [7:0]             ext_result_r;
  logic [7:0]             enables_r;
  logic [AAC_DELTA_W-1:0] delta_r;
  logic [7:0]             intv_r;
  logic [7:0]             thresh_r;
  logic [7:0]             flags_r;
  logic [7:0]             flags_nxt;
  logic                   bat_busy_r;
  logic                   ext_busy_r;
  logic                   bat_single_r;
  logic                   ext_single_r;
  logic                   bat_pend_r;
  logic                   ext_pend_r;
  logic                   bat_fire;
  logic                   ext_fire;
  logic                   bat_bg_ok;
  logic                   bat_sg_ok;
  logic                   ext_bg_ok;
  logic                   ext_sg_ok;
  logic                   bat_take_sg;
  logic                   bat_take_bg;
  logic                   ext_take_sg;
  logic                   ext_take_bg;
  logic                   bat_done;
  logic                   ext_done;
  logic                   bat_evt;
  logic                   ext_chg;
  logic                   ext_evt;
  logic                   ext_exceed;
  logic                   wr_start;
  logic                   wr_flags;

  assign wr_start = sfr_wr_i && sfr_addr_i == AAC_ADDR_START;
  assign wr_flags = sfr_wr_i && sfr_addr_i == AAC_ADDR_FLAGS;

  assign bat_bg_ok = power_mode_i == AAC_MODE_NORMAL;
  assign bat_sg_ok = power_mode_i == AAC_MODE_NORMAL
                  || power_mode_i == AAC_MODE_BATTERY;
  assign ext_bg_ok = power_mode_i == AAC_MODE_NORMAL
                  || power_mode_i == AAC_MODE_SLEEP;
  assign ext_sg_ok = bat_sg_ok;

  // Single start has priority over a pending background request
  assign bat_take_sg = !bat_busy_r && bat_start_r && bat_sg_ok;
  assign bat_take_bg = !bat_busy_r && !bat_take_sg && bat_pend_r
                    && bat_bg_ok;
  assign ext_take_sg = !ext_busy_r && ext_start_r && ext_sg_ok;
  assign ext_take_bg = !ext_busy_r && !ext_take_sg && ext_pend_r
                    && ext_bg_ok;

  assign bat_done = bat_conv_done_i && bat_busy_r;
  assign ext_done = ext_conv_done_i && ext_busy_r;

  assign bat_evt = bat_done && (bat_single_r || bat_conv_data_i < thresh_r);
  assign ext_chg = ext_done && !ext_single_r && ext_exceed;
  assign ext_evt = (ext_done && ext_single_r) || ext_chg;

  // Slow tick for background scheduling
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'd1;
      tick_r     <= 1'b0;
    end
  end

  // background off while interval is zero
  aac_intv_timer u_bat_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .tick_i     (tick_r),
    .enable_i   (bat_bg_ok),
    .period_i   (intv_r[AAC_INTV_BAT_LSB +: AAC_INTV_W]),
    .fire_o     (bat_fire)
  );

  aac_intv_timer u_ext_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .tick_i     (tick_r),
    .enable_i   (ext_bg_ok),
    .period_i   (intv_r[AAC_INTV_EXT_LSB +: AAC_INTV_W]),
    .fire_o     (ext_fire)
  );

  aac_delta_cmp u_ext_delta (
    .new_i    (ext_conv_data_i),
    .ref_i    (ext_result_r),
    .delta_i  (delta_r),
    .exceed_o (ext_exceed)
  );

  // Software-written configuration
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enables_r <= AAC_RST_BYTE;
      delta_r   <= '0;
      intv_r    <= AAC_RST_BYTE;
      thresh_r  <= AAC_RST_BYTE;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == AAC_ADDR_ENABLE) begin
        enables_r <= sfr_wdata_i;
      end
      if (sfr_addr_i == AAC_ADDR_DELTA) begin
        delta_r <= sfr_wdata_i[AAC_DELTA_W-1:0];
      end
      if (sfr_addr_i == AAC_ADDR_INTV) begin
        intv_r <= sfr_wdata_i;
      end
      if (sfr_addr_i == AAC_ADDR_THRESH) begin
        thresh_r <= sfr_wdata_i;
      end
    end
  end

  // start bits self-clear; a new write wins over the clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bat_start_r <= 1'b0;
      ext_start_r <= 1'b0;
    end else begin
      bat_start_r <= (bat_start_r && !bat_take_sg)
                  || (wr_start && sfr_wdata_i[AAC_START_BAT_BIT]);
      ext_start_r <= (ext_start_r && !ext_take_sg)
                  || (wr_start && sfr_wdata_i[AAC_START_EXT_BIT]);
    end
  end

  // Converter request and busy tracking
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bat_conv_req_o <= 1'b0;
      ext_conv_req_o <= 1'b0;
      bat_busy_r     <= 1'b0;
      ext_busy_r     <= 1'b0;
      bat_single_r   <= 1'b0;
      ext_single_r   <= 1'b0;
      bat_pend_r     <= 1'b0;
      ext_pend_r     <= 1'b0;
    end else begin
      bat_conv_req_o <= bat_take_sg || bat_take_bg;
      ext_conv_req_o <= ext_take_sg || ext_take_bg;
      if (bat_take_sg || bat_take_bg) begin
        bat_busy_r   <= 1'b1;
        bat_single_r <= bat_take_sg;
      end else if (bat_done) begin
        bat_busy_r <= 1'b0;
      end
      if (ext_take_sg || ext_take_bg) begin
        ext_busy_r   <= 1'b1;
        ext_single_r <= ext_take_sg;
      end else if (ext_done) begin
        ext_busy_r <= 1'b0;
      end
      // Pending strobe is dropped when its mode forbids it
      bat_pend_r <= bat_bg_ok && (bat_fire || (bat_pend_r && !bat_take_bg));
      ext_pend_r <= ext_bg_ok && (ext_fire || (ext_pend_r && !ext_take_bg));
    end
  end

  // results load only with their event
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bat_result_r  <= AAC_RST_BYTE;
      ext_result_r  <= AAC_RST_BYTE;
      ext_adc_irq_o <= 1'b0;
    end else begin
      if (bat_evt) begin
        bat_result_r <= bat_conv_data_i;
      end
      if (ext_evt) begin
        ext_result_r <= ext_conv_data_i;
      end
      ext_adc_irq_o <= ext_evt;
    end
  end

  // flags; hardware set wins over software clear
  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = flags_r & sfr_wdata_i;
    end
    flags_nxt[AAC_FLAG_BAT_BIT] = flags_nxt[AAC_FLAG_BAT_BIT] || bat_evt;
    flags_nxt[AAC_FLAG_EXT_BIT] = flags_nxt[AAC_FLAG_EXT_BIT] || ext_chg;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_r <= AAC_RST_BYTE;
    end else begin
      flags_r <= flags_nxt
               & ((8'h01 << AAC_FLAG_BAT_BIT) | (8'h01 << AAC_FLAG_EXT_BIT));
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psm_irq_o <= 1'b0;
    end else begin
      psm_irq_o <= |(flags_r & enables_r);
    end
  end

  // Registered read data, unmapped reads give zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= AAC_RST_BYTE;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        AAC_ADDR_START: begin
          sfr_rdata_o <= (8'(bat_start_r) << AAC_START_BAT_BIT)
                       | (8'(ext_start_r) << AAC_START_EXT_BIT);
        end
        AAC_ADDR_BATRES: sfr_rdata_o <= bat_result_r;
        AAC_ADDR_ENABLE: sfr_rdata_o <= enables_r;
        AAC_ADDR_EXTRES: sfr_rdata_o <= ext_result_r;
        AAC_ADDR_DELTA:  sfr_rdata_o <= 8'(delta_r);
        AAC_ADDR_FLAGS:  sfr_rdata_o <= flags_r;
        AAC_ADDR_INTV:   sfr_rdata_o <= intv_r;
        AAC_ADDR_THRESH: sfr_rdata_o <= thresh_r;
        default:         sfr_rdata_o <= AAC_RST_BYTE;
      endcase
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_bat_single_done;
    bat_done && bat_single_r;
  endsequence

  sequence s_ext_single_done;
    ext_done && ext_single_r;
  endsequence

  property p_sleep_no_bat;
    $past(power_mode_i) == AAC_MODE_SLEEP |-> !bat_conv_req_o;
  endproperty
  a_sleep_no_bat: assert property (p_sleep_no_bat)
    else $error("battery request in sleep mode");

  property p_batmode_bat_single;
    bat_conv_req_o && $past(power_mode_i) == AAC_MODE_BATTERY
      |-> $past(bat_start_r);
  endproperty
  a_batmode_bat_single: assert property (p_batmode_bat_single)
    else $error("battery background request in battery mode");

  property p_batmode_ext_single;
    ext_conv_req_o && $past(power_mode_i) == AAC_MODE_BATTERY
      |-> $past(ext_start_r);
  endproperty
  a_batmode_ext_single: assert property (p_batmode_ext_single)
    else $error("external background request in battery mode");

  property p_start_clear;
    bat_take_sg && !wr_start |=> !bat_start_r ##0 bat_conv_req_o;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("battery start bit did not clear on request");

  property p_bat_single_flag;
    s_bat_single_done |=> flags_r[AAC_FLAG_BAT_BIT]
      && bat_result_r == $past(bat_conv_data_i);
  endproperty
  a_bat_single_flag: assert property (p_bat_single_flag)
    else $error("single battery conversion raised no event");

  property p_bat_result_fresh;
    bat_result_r != $past(bat_result_r) |-> flags_r[AAC_FLAG_BAT_BIT];
  endproperty
  a_bat_result_fresh: assert property (p_bat_result_fresh)
    else $error("battery result changed without flag");

  property p_ext_result_evt;
    ext_result_r != $past(ext_result_r) |-> ext_adc_irq_o;
  endproperty
  a_ext_result_evt: assert property (p_ext_result_evt)
    else $error("external result changed without event");

  property p_ext_single_irq;
    s_ext_single_done |=> ext_adc_irq_o
      && ext_result_r == $past(ext_conv_data_i) ##1 !ext_adc_irq_o;
  endproperty
  a_ext_single_irq: assert property (p_ext_single_irq)
    else $error("single external conversion gave no one-cycle event");

  property p_ext_change_flag;
    ext_done && !ext_single_r && ext_exceed |=> flags_r[AAC_FLAG_EXT_BIT];
  endproperty
  a_ext_change_flag: assert property (p_ext_change_flag)
    else $error("external change beyond delta did not set flag");

  property p_ext_irq_route;
    flags_r[AAC_FLAG_EXT_BIT] && !enables_r[AAC_FLAG_EXT_BIT]
      && !(flags_r[AAC_FLAG_BAT_BIT] && enables_r[AAC_FLAG_BAT_BIT])
      |=> !psm_irq_o;
  endproperty
  a_ext_irq_route: assert property (p_ext_irq_route)
    else $error("disabled change flag reached interrupt");

  property p_bat_irq_route;
    flags_r[AAC_FLAG_BAT_BIT] && enables_r[AAC_FLAG_BAT_BIT] |=> psm_irq_o;
  endproperty
  a_bat_irq_route: assert property (p_bat_irq_route)
    else $error("enabled low-battery flag gave no interrupt");

  property p_ext_intv_off;
    intv_r[AAC_INTV_EXT_LSB +: AAC_INTV_W] == '0 |=> !ext_fire;
  endproperty
  a_ext_intv_off: assert property (p_ext_intv_off)
    else $error("external background ran with zero interval");

endmodule // aac_adc_ctrl

//--- tb/aac_conv_model.sv
`timescale 1ns/1ns
module aac_conv_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic [7:0] delay_i,
  input  wire logic [7:0] value_i,
  output logic            done_o,
  output logic [7:0]      data_o
);
  logic [7:0] cnt_r;

  // One conversion at a time, done after delay_i cycles
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 8'h00;
      done_o <= 1'b0;
      data_o <= 8'hA5;
    end else begin
      done_o <= 1'b0;
      // Toggled outside done so stale data never looks valid
      data_o <= ~data_o;
      if (req_i) begin
        cnt_r <= delay_i;
      end else if (cnt_r == 8'h01) begin
        cnt_r  <= 8'h00;
        done_o <= 1'b1;
        data_o <= value_i;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule // aac_conv_model

//--- tb/aac_adc_ctrl_tb.sv
`timescale 1ns/1ns
module aac_adc_ctrl_tb;
  import aac_pkg::*;
  // Short tick keeps background runs brief
  localparam int TICK = 10;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  aac_mode_t  power_mode_i = AAC_MODE_NORMAL;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic       sfr_rd_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic       bat_conv_req_o;
  logic       bat_conv_done_i;
  logic [7:0] bat_conv_data_i;
  logic       ext_conv_req_o;
  logic       ext_conv_done_i;
  logic [7:0] ext_conv_data_i;
  logic       psm_irq_o;
  logic       ext_adc_irq_o;
  logic [7:0] bat_val = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_dly = 8'h02;
  logic [7:0] rd_v;
  int mismatches = 0;
  int checks_done = 0;
  int n_bat_req = 0;
  int n_ext_req = 0;
  int n_ext_irq = 0;
  int n_bat_done = 0;
  int snap;

  always #50 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i) begin
    n_bat_req  += int'(bat_conv_req_o === 1'b1);
    n_ext_req  += int'(ext_conv_req_o === 1'b1);
    n_ext_irq  += int'(ext_adc_irq_o === 1'b1);
    n_bat_done += int'(bat_conv_done_i === 1'b1);
  end

  aac_adc_ctrl #(.TICK_CYCLES(TICK)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .power_mode_i(power_mode_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
    .bat_conv_req_o(bat_conv_req_o), .bat_conv_done_i(bat_conv_done_i),
    .bat_conv_data_i(bat_conv_data_i), .ext_conv_req_o(ext_conv_req_o),
    .ext_conv_done_i(ext_conv_done_i), .ext_conv_data_i(ext_conv_data_i),
    .psm_irq_o(psm_irq_o), .ext_adc_irq_o(ext_adc_irq_o));

  aac_conv_model u_bat (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(bat_conv_req_o),
    .delay_i(8'h04), .value_i(bat_val), .done_o(bat_conv_done_i),
    .data_o(bat_conv_data_i));

  aac_conv_model u_ext (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(ext_conv_req_o),
    .delay_i(ext_dly), .value_i(ext_val), .done_o(ext_conv_done_i),
    .data_o(ext_conv_data_i));

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic set_mode(input aac_mode_t m);
    @(posedge core_clk_i);
    power_mode_i <= m;
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= d;
    sfr_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b0;
    #1 d = sfr_rdata_o;
  endtask

  task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_read(a, rd_v);
    check_byte(rd_v, exp);
  endtask

  // Bounded wait on battery done (sel 0) or external event (sel 1)
  task automatic wait_evt(input bit sel, input int target);
    for (int i = 0; i < 200; i++) begin
      @(posedge core_clk_i);
      #1;
      if ((sel ? n_ext_irq : n_bat_done) >= target) return;
    end
    mismatches++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, target);
    print_verdict();
  endtask

  // Request counts of both channels over a window
  task automatic span(input int n, input int bl, input int bh,
                      input int el, input int eh);
    int sb;
    int se;
    sb = n_bat_req;
    se = n_ext_req;
    cyc(n);
    check_count(n_bat_req - sb, bl, bh);
    check_count(n_ext_req - se, el, eh);
  endtask

  task automatic t_reset();
    logic [7:0] addrs [9];
    addrs = '{AAC_ADDR_START, AAC_ADDR_BATRES, AAC_ADDR_ENABLE,
              AAC_ADDR_EXTRES, AAC_ADDR_DELTA, AAC_ADDR_FLAGS,
              AAC_ADDR_INTV, AAC_ADDR_THRESH, 8'h10};
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    power_mode_i <= AAC_MODE_NORMAL;
    cyc(3);
    rst_n_i <= 1'b1;
    span(40, 0, 0, 0, 0); // background off after reset
    sfr_write(AAC_ADDR_BATRES, 8'hFF);
    sfr_write(AAC_ADDR_EXTRES, 8'hFF);
    sfr_write(8'h10, 8'hFF);
    foreach (addrs[i]) read_chk(addrs[i], AAC_RST_BYTE);
    $display("TEST reset done");
  endtask

  task automatic t_bat_single();
    set_mode(AAC_MODE_BATTERY);
    bat_val <= 8'h80;
    sfr_write(AAC_ADDR_ENABLE, 8'h0C);
    sfr_write(AAC_ADDR_THRESH, 8'h10);
    snap = n_bat_done;
    sfr_write(AAC_ADDR_START, 8'h01);
    read_chk(AAC_ADDR_START, 8'h00); // start bit self-clears
    wait_evt(1'b0, snap + 1); // single start in battery mode
    read_chk(AAC_ADDR_BATRES, 8'h80); // result loads with flag
    read_chk(AAC_ADDR_FLAGS, 8'h04); // single completion sets flag
    check_byte({7'h00, psm_irq_o}, 8'h01); // enabled flag interrupts
    sfr_write(AAC_ADDR_FLAGS, 8'h00);
    cyc(2);
    #1 check_byte({7'h00, psm_irq_o}, 8'h00); // cleared flag drops
    $display("TEST bat_single done");
  endtask

  task automatic t_ext_single();
    set_mode(AAC_MODE_NORMAL);
    ext_val <= 8'h55;
    snap = n_ext_irq;
    sfr_write(AAC_ADDR_START, 8'h04);
    wait_evt(1'b1, snap + 1); // single completion event
    read_chk(AAC_ADDR_EXTRES, 8'h55); // result held
    read_chk(AAC_ADDR_FLAGS, 8'h00); // no flag for this event
    read_chk(AAC_ADDR_START, 8'h00); // start bit self-clears
    $display("TEST ext_single done");
  endtask

  task automatic t_ext_bg();
    sfr_write(AAC_ADDR_DELTA, 8'h02); // delta after single, then interval
    ext_val <= 8'h56;
    ext_dly <= 8'h07;
    snap = n_ext_irq;
    sfr_write(AAC_ADDR_INTV, 8'h04);
    span(40, 0, 0, 3, 5); // background runs in normal mode
    check_count(n_ext_irq - snap, 0, 0); // change within delta
    read_chk(AAC_ADDR_EXTRES, 8'h55); // no event, no update
    ext_val <= 8'h60;
    wait_evt(1'b1, snap + 1); // change beyond delta raises event
    read_chk(AAC_ADDR_FLAGS, 8'h08); // change flag at bit 3
    read_chk(AAC_ADDR_EXTRES, 8'h60); // update on event
    check_byte({7'h00, psm_irq_o}, 8'h01); // enabled change flag
    sfr_write(AAC_ADDR_ENABLE, 8'h04);
    cyc(2);
    #1 check_byte({7'h00, psm_irq_o}, 8'h00); // masked change flag
    sfr_write(AAC_ADDR_FLAGS, 8'h00);
    $display("TEST ext_bg done");
  endtask

  task automatic t_modes();
    set_mode(AAC_MODE_SLEEP);
    sfr_write(AAC_ADDR_THRESH, 8'h40);
    bat_val <= 8'h30;
    sfr_write(AAC_ADDR_INTV, 8'h05);
    cyc(10);
    span(40, 0, 0, 3, 5); // sleep: external background only
    set_mode(AAC_MODE_BATTERY);
    cyc(10);
    span(40, 0, 0, 0, 0); // battery mode: no background
    snap = n_bat_done;
    sfr_write(AAC_ADDR_START, 8'h01); // single start below threshold
    wait_evt(1'b0, snap + 1); // single completes in battery mode
    read_chk(AAC_ADDR_BATRES, 8'h30); // one update for both causes
    read_chk(AAC_ADDR_FLAGS, 8'h04); // single event sets the flag
    set_mode(AAC_MODE_NORMAL);
    span(40, 3, 5, 3, 5); // normal mode: both run
    read_chk(AAC_ADDR_BATRES, 8'h30); // below threshold
    read_chk(AAC_ADDR_FLAGS, 8'h04); // low battery flag only
    check_byte({7'h00, psm_irq_o}, 8'h01); // background low battery
    $display("TEST modes done");
  endtask

  initial begin
    t_reset();
    t_bat_single();
    t_ext_single();
    t_ext_bg();
    t_modes();
    t_reset();
    print_verdict();
  end

  initial begin
    #10_000_000;
    mismatches++;
    print_verdict();
  end
endmodule // aac_adc_ctrl_tb
